// [ucb_params.svh]
// Summary of operation
// - serial link fixed at 8N1 framing
// - link starts at 9600 bit/s after reset
// - send 0x4F then 0x4B after reset
// - unknown command characters silently dropped
// - 655 ms byte gap flushes receiver
// - 0x53 starts bus transaction, 0x50 stops it
// - 0x52 register read, 0x57 register write
// - bus write: addr, count, data, stop
// - bus read fetches count bytes to host
// - register write takes index then data pairs
// - register read runs on index arrival, register write on data arrival
// - register read returns bytes in order
// - 0x4F drives byte onto output pins
// - 0x49 then stop returns pin levels
// - write then read uses repeated start
// - write then write uses repeated start
// - power-down only after 0x5A 0x5A 0xA5
// - asleep: oscillator halted, link ignored
// - entering sleep releases wake pin high
// - wake pin low resumes normal operation
// - rate 7.3728 MHz over 16+divider, high commits
`ifndef UCB_PARAMS_SVH
`define UCB_PARAMS_SVH
`define UCB_MCLK_HZ 100000000
`define UCB_OSC_HZ 7372800
`define UCB_OVS 16
`define UCB_DIV_OFS 16
`define UCB_ACC_W 34
`define UCB_INC (`UCB_OSC_HZ / 100)
`define UCB_LIM_UNIT (`UCB_MCLK_HZ / 100 / `UCB_OVS)
`define UCB_DIV_RST 16'h02f0
`define UCB_TIMEOUT_MS 655
`define UCB_TIMEOUT_CYC (`UCB_TIMEOUT_MS * (`UCB_MCLK_HZ / 1000))
`define UCB_TO_W 27
`define UCB_RX_MID 4'h7
`define UCB_TX_LAST 4'hf
`define UCB_TX_BITS 4'ha
`define UCB_CH_START 8'h53
`define UCB_CH_STOP 8'h50
`define UCB_CH_RDREG 8'h52
`define UCB_CH_WRREG 8'h57
`define UCB_CH_GPI 8'h49
`define UCB_CH_GPO 8'h4f
`define UCB_CH_PD 8'h5a
`define UCB_PD_KEY1 8'h5a
`define UCB_PD_KEY2 8'ha5
`define UCB_BOOT0 8'h4f
`define UCB_BOOT1 8'h4b
`define UCB_REG_DIV_LO 8'h00
`define UCB_REG_DIV_HI 8'h01
`define UCB_REG_PIN 8'h04
`define UCB_REG_RSVD 8'h05
`define UCB_REG_LAST_RW 8'h09
`define UCB_REG_STAT 8'h0a
`define UCB_STAT_FILL 4'hf
`define UCB_OP_START 3'h0
`define UCB_OP_RSTART 3'h1
`define UCB_OP_WRITE 3'h2
`define UCB_OP_READ 3'h3
`define UCB_OP_READ_LAST 3'h4
`define UCB_OP_STOP 3'h5
`define UCB_SYNC_RST 10'h200
`endif

// [ucb_pkg.sv]
`default_nettype none
package ucb_pkg;
  // command interpreter states
  typedef enum logic [4:0] {
    ST_BOOT0, ST_BOOT1, ST_IDLE, ST_ADDR, ST_ADR_WR, ST_CNT, ST_WDATA,
    ST_FRAME_END, ST_BUS, ST_SEND, ST_RD_NEXT, ST_REG_RIDX, ST_REG_WIDX,
    ST_REG_WDAT, ST_GPO, ST_GPO_P, ST_GPI_P, ST_Z1, ST_Z2, ST_SLEEP
  } ucb_state_t;
endpackage : ucb_pkg
`default_nettype wire

// [ucb_uart_rx.sv]
`include "ucb_params.svh"
`default_nettype none
module ucb_uart_rx
  import ucb_pkg::*;
(
  input wire logic mclk, // core clock
  input wire logic rst_b, // async reset, active low
  input wire logic ovs_tick, // 16x bit-rate strobe
  input wire logic rx_line, // filtered serial input
  input wire logic take, // consumer takes held byte
  input wire logic flush, // drop held byte
  output logic valid, // byte waiting
  output logic [7:0] data // held byte
);
  logic busy; // inside a frame
  logic [3:0] tick_cnt; // ticks within bit
  logic [3:0] bit_cnt; // 0 start, 1..8 data, 9 stop
  logic [7:0] shift; // lsb-first assembly
  logic done; // good stop bit seen

  // frame capture, sampled mid-bit
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      busy <= 1'b0;
      tick_cnt <= 4'h0;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!busy) begin
        if (!rx_line) begin // start edge
          busy <= 1'b1;
          tick_cnt <= 4'h0;
          bit_cnt <= 4'h0;
        end
      end else if (ovs_tick) begin
        tick_cnt <= tick_cnt + 4'h1;
        if (tick_cnt == `UCB_RX_MID) begin
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == 4'h0) begin
            busy <= ~rx_line; // glitch, not a start bit
          end else if (bit_cnt == 4'h9) begin
            busy <= 1'b0;
            done <= rx_line; // framing error drops the byte
          end else begin
            shift <= {rx_line, shift[7:1]}; // eight data bits, no parity
          end
        end
      end
    end
  end

  // single holding byte; a new byte beats a same-cycle take
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      valid <= 1'b0;
      data <= 8'h00;
    end else if (done && !flush) begin
      valid <= 1'b1;
      data <= shift;
    end else if (take || flush) begin
      valid <= 1'b0;
    end
  end
endmodule : ucb_uart_rx
`default_nettype wire

// [ucb_uart_tx.sv]
`include "ucb_params.svh"
`default_nettype none
module ucb_uart_tx
  import ucb_pkg::*;
(
  input wire logic mclk, // core clock
  input wire logic rst_b, // async reset, active low
  input wire logic ovs_tick, // 16x bit-rate strobe
  input wire logic send, // load byte, one cycle
  input wire logic [7:0] byte_in, // byte to send
  output logic ready, // idle, may load
  output logic tx_line // serial output
);
  logic [8:0] frame; // data then stop bit
  logic [3:0] tick_cnt; // ticks within bit
  logic [3:0] bits_left; // bit periods remaining

  assign ready = (bits_left == 4'h0);

  // start, eight data lsb first, one stop
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      frame <= 9'h1ff;
      tick_cnt <= 4'h0;
      bits_left <= 4'h0;
      tx_line <= 1'b1;
    end else if (ready) begin
      if (send) begin
        frame <= {1'b1, byte_in};
        tick_cnt <= 4'h0;
        bits_left <= `UCB_TX_BITS;
        tx_line <= 1'b0;
      end
    end else if (ovs_tick) begin
      tick_cnt <= tick_cnt + 4'h1;
      if (tick_cnt == `UCB_TX_LAST) begin
        bits_left <= bits_left - 4'h1;
        if (bits_left != 4'h1) begin
          tx_line <= frame[0];
          frame <= {1'b1, frame[8:1]};
        end
      end
    end
  end
endmodule : ucb_uart_tx
`default_nettype wire

// [ucb_bridge.sv]
`include "ucb_params.svh"
`default_nettype none
module ucb_bridge
  import ucb_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `UCB_TIMEOUT_CYC // byte-gap limit in mclk cycles
) (
  input wire logic mclk, // core clock, 100 MHz
  input wire logic rst_b, // async reset, active low
  input wire logic uart_rx, // host serial in
  output logic uart_tx, // host serial out
  output logic bus_req, // bus engine request, held
  output logic [2:0] bus_op, // bus engine operation
  output logic [7:0] bus_wdata, // byte for start/write ops
  input wire logic bus_done, // engine finished, one cycle
  input wire logic [7:0] bus_rdata, // byte read by engine
  input wire logic [3:0] bus_status, // engine status code
  input wire logic [7:0] gpio_in, // pin levels
  output logic [7:0] gpio_out, // output pin latch
  input wire logic wake_pin_n_in, // wake pin level
  output logic wake_pin_n_out, // wake pin drive value
  output logic wake_pin_n_oe, // wake pin drive enable
  output logic osc_run // oscillator enable
);
  logic [9:0] s1, s2, s3, filt; // {rx, wake, gpio} synchroniser
  logic [`UCB_ACC_W-1:0] acc; // fractional rate accumulator
  logic [`UCB_ACC_W-1:0] lim; // accumulator wrap point
  logic ovs_tick; // 16x bit-rate strobe
  logic [15:0] active_div; // divider in use
  logic [7:0] regs [0:9]; // read/write register storage
  ucb_state_t state, bus_ret; // current and return state
  logic in_txn; // bus transaction open
  logic [7:0] addr; // target address byte
  logic [7:0] cnt; // bytes still to move
  logic [7:0] reg_widx; // register index being written
  logic [7:0] reg_q; // register read value
  logic tx_go, tx_rdy; // transmitter handshake
  logic [7:0] tx_byte; // byte for transmitter
  logic rx_valid, rx_take, rx_flush; // receiver handshake
  logic [7:0] rx_data; // received byte
  logic wait_st, got; // waiting for a byte, byte taken
  logic [`UCB_TO_W-1:0] idle_cnt; // cycles since last byte
  logic to_hit; // byte gap reached limit
  logic wake_prev; // filtered wake, delayed
  logic wake_fall; // host pulled wake low
  logic reg_we; // register write strobe
  logic cmd_ok; // character is a known command
  logic rx_f, wake_f; // filtered rx and wake
  logic [7:0] pins; // filtered pin levels

  // three-stage sync; a bit moves once stages two and three agree
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= `UCB_SYNC_RST;
      s2 <= `UCB_SYNC_RST;
      s3 <= `UCB_SYNC_RST;
      filt <= `UCB_SYNC_RST;
    end else begin
      s1 <= {uart_rx, wake_pin_n_in, gpio_in};
      s2 <= s1;
      s3 <= s2;
      filt <= (s3 & ~(s2 ^ s3)) | (filt & (s2 ^ s3));
    end
  end
  assign rx_f = filt[9];
  assign wake_f = filt[8];
  assign pins = filt[7:0];

  // 16x tick = osc / (16 + div) * 16, done as a fractional accumulator
  assign lim = `UCB_ACC_W'(`UCB_LIM_UNIT) * (`UCB_ACC_W'(active_div) + `UCB_ACC_W'(`UCB_DIV_OFS));
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      acc <= '0;
      ovs_tick <= 1'b0;
    end else if (acc + `UCB_ACC_W'(`UCB_INC) >= lim) begin
      acc <= acc + `UCB_ACC_W'(`UCB_INC) - lim;
      ovs_tick <= 1'b1;
    end else begin
      acc <= acc + `UCB_ACC_W'(`UCB_INC);
      ovs_tick <= 1'b0;
    end
  end

  ucb_uart_rx u_rx (
    .mclk(mclk),
    .rst_b(rst_b),
    .ovs_tick(ovs_tick),
    .rx_line(rx_f),
    .take(rx_take),
    .flush(rx_flush),
    .valid(rx_valid),
    .data(rx_data)
  );

  ucb_uart_tx u_tx (
    .mclk(mclk),
    .rst_b(rst_b),
    .ovs_tick(ovs_tick),
    .send(tx_go),
    .byte_in(tx_byte),
    .ready(tx_rdy),
    .tx_line(uart_tx)
  );

  // states that sit waiting for a host byte
  always_comb begin
    wait_st = 1'b0;
    case (state)
      ST_ADDR, ST_CNT, ST_WDATA, ST_FRAME_END, ST_REG_RIDX, ST_REG_WIDX,
      ST_REG_WDAT, ST_GPO, ST_GPO_P, ST_GPI_P, ST_Z1, ST_Z2: wait_st = 1'b1;
      default: wait_st = 1'b0;
    endcase
  end
  // bytes wait in the receiver while an action runs
  assign got = rx_valid && (wait_st || state == ST_IDLE);
  assign rx_take = got;
  assign rx_flush = to_hit || state == ST_SLEEP; // asleep, host traffic dropped
  assign reg_we = got && state == ST_REG_WDAT;
  assign wake_fall = wake_prev && !wake_f;
  assign cmd_ok = rx_data == `UCB_CH_START || rx_data == `UCB_CH_STOP || rx_data == `UCB_CH_RDREG
    || rx_data == `UCB_CH_WRREG || rx_data == `UCB_CH_GPI || rx_data == `UCB_CH_GPO
    || rx_data == `UCB_CH_PD;

  // byte-gap watchdog, only mid-frame
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      idle_cnt <= '0;
    end else if (!wait_st || got || to_hit) begin
      idle_cnt <= '0;
    end else begin
      idle_cnt <= idle_cnt + `UCB_TO_W'(1);
    end
  end
  assign to_hit = wait_st && !got && idle_cnt == `UCB_TO_W'(TIMEOUT_CYC - 1);

  // register read mux; reserved and unmapped read zero
  always_comb begin
    reg_q = 8'h00;
    if (rx_data == `UCB_REG_PIN) begin
      reg_q = pins;
    end else if (rx_data == `UCB_REG_STAT) begin
      reg_q = {`UCB_STAT_FILL, bus_status};
    end else if (rx_data == `UCB_REG_RSVD) begin
      reg_q = 8'h00;
    end else if (rx_data <= `UCB_REG_LAST_RW) begin
      reg_q = regs[rx_data[3:0]];
    end
  end

  // register file, pin latch and divider commit
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 10; i++) begin
        regs[i] <= 8'h00;
      end
      regs[0] <= 8'(`UCB_DIV_RST);
      regs[1] <= 8'(`UCB_DIV_RST >> 8);
      active_div <= `UCB_DIV_RST; // 9600 bit/s until reprogrammed
      gpio_out <= 8'h00;
    end else if (got && state == ST_GPO) begin
      gpio_out <= rx_data; // same effect as a pin register write
    end else if (reg_we) begin // written as the data arrives
      if (reg_widx == `UCB_REG_PIN) begin
        gpio_out <= rx_data;
      end else if (reg_widx <= `UCB_REG_LAST_RW && reg_widx != `UCB_REG_RSVD) begin
        regs[reg_widx[3:0]] <= rx_data;
      end
      if (reg_widx == `UCB_REG_DIV_HI) begin
        active_div <= {rx_data, regs[0]}; // high byte commits the new rate
      end
    end
  end

  // hand one operation to the bus engine and park until it is done
  task automatic issue(input logic [2:0] op, input logic [7:0] wd, input ucb_state_t ret);
    bus_req <= 1'b1;
    bus_op <= op;
    bus_wdata <= wd;
    bus_ret <= ret;
    state <= ST_BUS;
  endtask : issue

  // command interpreter
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_BOOT0;
      bus_ret <= ST_IDLE;
      bus_req <= 1'b0;
      bus_op <= `UCB_OP_STOP;
      bus_wdata <= 8'h00;
      in_txn <= 1'b0;
      addr <= 8'h00;
      cnt <= 8'h00;
      reg_widx <= 8'h00;
      tx_go <= 1'b0;
      tx_byte <= 8'h00;
    end else begin
      tx_go <= 1'b0;
      if (to_hit) begin // stale frame dropped; an open transaction is closed
        if (in_txn) begin
          in_txn <= 1'b0;
          issue(`UCB_OP_STOP, 8'h00, ST_IDLE);
        end else begin
          state <= ST_IDLE;
        end
      end else begin
        case (state)
          ST_BOOT0: begin
            tx_byte <= `UCB_BOOT0; // start-up greeting
            bus_ret <= ST_BOOT1;
            state <= ST_SEND;
          end
          ST_BOOT1: begin
            tx_byte <= `UCB_BOOT1;
            bus_ret <= ST_IDLE;
            state <= ST_SEND;
          end
          ST_IDLE: begin
            if (got) begin
              if (rx_data == `UCB_CH_START) begin
                state <= ST_ADDR;
              end else if (rx_data == `UCB_CH_RDREG) begin
                state <= ST_REG_RIDX;
              end else if (rx_data == `UCB_CH_WRREG) begin
                state <= ST_REG_WIDX;
              end else if (rx_data == `UCB_CH_GPO) begin
                state <= ST_GPO;
              end else if (rx_data == `UCB_CH_GPI) begin
                state <= ST_GPI_P;
              end else if (rx_data == `UCB_CH_PD) begin
                state <= ST_Z1;
              end else if (rx_data == `UCB_CH_STOP && in_txn) begin
                in_txn <= 1'b0;
                issue(`UCB_OP_STOP, 8'h00, ST_IDLE);
              end
              // anything else is dropped without reply
            end
          end
          ST_ADDR: begin
            if (got) begin // a still-open transaction chains by repeated start
              addr <= rx_data; // bit 0 gives direction, host's duty
              in_txn <= 1'b1;
              issue(in_txn ? `UCB_OP_RSTART : `UCB_OP_START, rx_data, ST_ADR_WR);
            end
          end
          ST_ADR_WR: issue(`UCB_OP_WRITE, addr, ST_CNT); // address the target
          ST_CNT: begin
            if (got) begin
              cnt <= rx_data;
              if (rx_data == 8'h00) begin
                state <= ST_FRAME_END;
              end else if (addr[0]) begin // read exactly count bytes
                issue(rx_data == 8'h01 ? `UCB_OP_READ_LAST : `UCB_OP_READ, 8'h00, ST_RD_NEXT);
              end else begin
                state <= ST_WDATA;
              end
            end
          end
          ST_WDATA: begin
            if (got) begin // each data byte forwarded in order
              cnt <= cnt - 8'h01;
              issue(`UCB_OP_WRITE, rx_data, cnt == 8'h01 ? ST_FRAME_END : ST_WDATA);
            end
          end
          ST_BUS: begin
            if (bus_req && bus_done) begin // engine done before the next byte is read
              bus_req <= 1'b0;
              if (bus_op == `UCB_OP_READ || bus_op == `UCB_OP_READ_LAST) begin
                tx_byte <= bus_rdata; // forward to host
                cnt <= cnt - 8'h01;
                state <= ST_SEND;
              end else begin
                state <= bus_ret;
              end
            end
          end
          ST_SEND: begin
            if (tx_rdy && !tx_go) begin
              tx_go <= 1'b1;
              state <= bus_ret;
            end
          end
          ST_RD_NEXT: begin
            if (cnt == 8'h00) begin
              state <= ST_FRAME_END;
            end else begin
              issue(cnt == 8'h01 ? `UCB_OP_READ_LAST : `UCB_OP_READ, 8'h00, ST_RD_NEXT);
            end
          end
          ST_FRAME_END: begin
            if (got && rx_data == `UCB_CH_STOP) begin
              in_txn <= 1'b0;
              issue(`UCB_OP_STOP, 8'h00, ST_IDLE);
            end else if (got && rx_data == `UCB_CH_START) begin
              state <= ST_ADDR; // no stop: next frame chains
            end
          end
          ST_REG_RIDX: begin
            if (got && rx_data == `UCB_CH_STOP) begin
              state <= ST_IDLE;
            end else if (got) begin
              tx_byte <= reg_q; // one byte per index, list order
              bus_ret <= ST_REG_RIDX;
              state <= ST_SEND;
            end
          end
          ST_REG_WIDX: begin
            if (got && rx_data == `UCB_CH_STOP) begin
              state <= ST_IDLE;
            end else if (got) begin
              reg_widx <= rx_data; // index, then its data byte
              state <= ST_REG_WDAT;
            end
          end
          ST_REG_WDAT: begin
            if (got) begin
              state <= ST_REG_WIDX;
            end
          end
          ST_GPO: begin
            if (got) begin
              state <= ST_GPO_P;
            end
          end
          ST_GPO_P: begin
            if (got) begin
              state <= ST_IDLE;
            end
          end
          ST_GPI_P: begin
            if (got && rx_data == `UCB_CH_STOP) begin
              tx_byte <= pins;
              bus_ret <= ST_IDLE;
              state <= ST_SEND;
            end else if (got) begin
              state <= ST_IDLE;
            end
          end
          ST_Z1: begin
            if (got) begin
              state <= (rx_data == `UCB_PD_KEY1) ? ST_Z2 : ST_IDLE;
            end
          end
          ST_Z2: begin
            if (got) begin
              state <= (rx_data == `UCB_PD_KEY2) ? ST_SLEEP : ST_IDLE;
            end
          end
          ST_SLEEP: begin
            if (wake_fall) begin
              state <= ST_IDLE; // host pulled wake low
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // oscillator and wake pin; pin held low while running, released asleep
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      osc_run <= 1'b1;
      wake_pin_n_out <= 1'b0;
      wake_pin_n_oe <= 1'b1;
      wake_prev <= 1'b0; // pin sits low while running; a high reset would fake a fall
    end else begin
      osc_run <= (state != ST_SLEEP);
      wake_pin_n_out <= 1'b0;
      wake_pin_n_oe <= (state != ST_SLEEP); // pull-up takes it high
      wake_prev <= wake_f;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_chain;
    state == ST_FRAME_END && got && rx_data == `UCB_CH_START;
  endsequence
  sequence s_chain_addr;
    state == ST_ADDR && in_txn && got;
  endsequence
  sequence s_pd_key;
    state == ST_Z2 && got && rx_data == `UCB_PD_KEY2;
  endsequence

  property p_unknown;
    state == ST_IDLE && got && !cmd_ok |=> state == ST_IDLE && !bus_req && !tx_go;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown command acted on");
  property p_timeout;
    to_hit |=> idle_cnt == '0 && !wait_st;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout did not end frame");
  property p_chain;
    s_chain |=> state == ST_ADDR && in_txn && !bus_req;
  endproperty
  a_chain: assert property (p_chain) else $error("chained frame closed the bus");
  property p_rstart;
    s_chain_addr |=> bus_req && bus_op == `UCB_OP_RSTART && bus_wdata == $past(rx_data);
  endproperty
  a_rstart: assert property (p_rstart) else $error("chained frame missed repeated start");
  property p_stop;
    state == ST_FRAME_END && got && rx_data == `UCB_CH_STOP |=> bus_req && bus_op == `UCB_OP_STOP && !in_txn;
  endproperty
  a_stop: assert property (p_stop) else $error("stop character did not stop bus");
  property p_div_commit;
    reg_we && reg_widx == `UCB_REG_DIV_HI |=> active_div == {$past(rx_data), regs[0]};
  endproperty
  a_div_commit: assert property (p_div_commit) else $error("divider not committed");
  property p_div_hold;
    !(reg_we && reg_widx == `UCB_REG_DIV_HI) |=> $stable(active_div);
  endproperty
  a_div_hold: assert property (p_div_hold) else $error("divider changed without high write");
  property p_pd_abort;
    state == ST_Z2 && got && rx_data != `UCB_PD_KEY2 |=> state == ST_IDLE ##1 osc_run;
  endproperty
  a_pd_abort: assert property (p_pd_abort) else $error("wrong key entered sleep");
  property p_pd_enter;
    s_pd_key |=> state == ST_SLEEP ##1 !osc_run && !wake_pin_n_oe;
  endproperty
  a_pd_enter: assert property (p_pd_enter) else $error("sleep entry incomplete");
  property p_wake;
    state == ST_SLEEP && wake_fall |=> state == ST_IDLE ##1 osc_run && wake_pin_n_oe;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not resume");
  property p_bus_hold;
    bus_req && !bus_done |=> bus_req && $stable(bus_op) && $stable(bus_wdata) && state == ST_BUS;
  endproperty
  a_bus_hold: assert property (p_bus_hold) else $error("bus request dropped early");
endmodule : ucb_bridge
`default_nettype wire

// [ucb_host.sv]
`default_nettype none
// host serial port model
module ucb_host (
  input wire logic tx_line, // device serial out
  output logic rx_line // device serial in
);
  timeunit 1ns;
  timeprecision 1ps;
  real bit_ns = 104166.7; // 9600 bit/s until reprogrammed
  logic [7:0] got[$]; // bytes heard from device
  initial rx_line = 1'b1;
  // 8n1, lsb first; bytes go back to back so gaps stay short
  task automatic put(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      rx_line = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i - 1];
      #(bit_ns);
    end
  endtask : put
  // receiver samples mid bit
  always begin
    logic [7:0] r;
    @(negedge tx_line);
    #(bit_ns * 1.5);
    for (int i = 0; i < 8; i++) begin
      r[i] = tx_line;
      #(bit_ns);
    end
    got.push_back(r);
  end
endmodule : ucb_host
`default_nettype wire

// [testbench.sv]
`include "ucb_params.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TO = 200000; // shortened gap limit, above one slow byte
  logic mclk = 1'b0, rst_b = 1'b0, uart_rx, uart_tx, bus_req, bus_done = 1'b0;
  logic wk_out, wk_oe, osc_run, host_wake_n = 1'b1;
  logic [2:0] bus_op;
  logic [7:0] bus_wdata, gpio_out;
  logic [10:0] ops[$]; // engine log {op, byte}
  int n_errors = 0, tests_run = 0, cnt = 0;
  wire logic wk_lvl = (wk_oe ? wk_out : 1'b1) & host_wake_n; // pulled up pin
  always #5 mclk = ~mclk;
  ucb_host h (.tx_line(uart_tx), .rx_line(uart_rx));
  ucb_bridge #(.TIMEOUT_CYC(TO)) dut (.mclk(mclk), .rst_b(rst_b), .uart_rx(uart_rx), .uart_tx(uart_tx),
    .bus_req(bus_req), .bus_op(bus_op), .bus_wdata(bus_wdata), .bus_done(bus_done), .bus_rdata(8'h3c),
    .bus_status(4'h3), .gpio_in(8'h96), .gpio_out(gpio_out), .wake_pin_n_in(wk_lvl),
    .wake_pin_n_out(wk_out), .wake_pin_n_oe(wk_oe), .osc_run(osc_run));
  // bus engine stand-in: done three cycles after each request
  always @(negedge mclk) begin
    bus_done <= 1'b0;
    if (!bus_req) cnt <= 0;
    else if (cnt == 2) begin
      bus_done <= 1'b1;
      cnt <= 3;
      ops.push_back({bus_op, bus_wdata});
    end else if (cnt < 2) cnt <= cnt + 1;
  end
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic rx(input logic [7:0] e);
    for (int i = 0; i < 300000 && h.got.size() == 0; i++) @(posedge mclk);
    chk("reply", {3'h0, e}, h.got.size() ? {3'h0, h.got.pop_front()} : 'x);
  endtask : rx
  // byte only matters for start and write ops
  task automatic op(input logic [2:0] o, input logic [7:0] d);
    logic [10:0] g;
    g = ops.size() ? ops.pop_front() : 'x;
    chk("bus op", o > 3'h2 ? {o, 8'h00} : {o, d}, o > 3'h2 ? {g[10:8], 8'h00} : g);
  endtask : op
  task automatic send(input logic [63:0] s, input int n);
    for (int i = n - 1; i >= 0; i--) h.put(s[8*i +: 8]);
  endtask : send
  task automatic t_boot;
    rx(`UCB_BOOT0);
    rx(`UCB_BOOT1);
  endtask : t_boot
  task automatic t_regs;
    send(64'h5700000100, 5); // divider to zero, high byte commits
    h.bit_ns = 1.0e9 / 460800.0;
    send(64'h5052040a50, 5);
    rx(8'h96);
    rx(8'hf3);
  endtask : t_regs
  task automatic t_gpio;
    send(64'h414f5a504950, 6); // stray char, quick out, quick
    chk("pins", {3'h0, 8'h5a}, {3'h0, gpio_out});
    rx(8'h96);
  endtask : t_gpio
  task automatic t_bus;
    send(64'h534001ab53410150, 8); // write then read, no stop between
    rx(8'h3c);
    repeat (100) @(posedge mclk);
    op(`UCB_OP_START, 8'h40);
    op(`UCB_OP_WRITE, 8'h40);
    op(`UCB_OP_WRITE, 8'hab);
    op(`UCB_OP_RSTART, 8'h41);
    op(`UCB_OP_WRITE, 8'h41);
    op(`UCB_OP_READ_LAST, 8'h00);
    op(`UCB_OP_STOP, 8'h00);
    send(64'h534001ab5340, 6); // chained second write, then host goes quiet
    repeat (TO + 1000) @(posedge mclk);
    op(`UCB_OP_START, 8'h40);
    op(`UCB_OP_WRITE, 8'h40);
    op(`UCB_OP_WRITE, 8'hab);
    op(`UCB_OP_RSTART, 8'h40);
    op(`UCB_OP_WRITE, 8'h40);
    op(`UCB_OP_STOP, 8'h00);
  endtask : t_bus
  task automatic t_sleep;
    send(64'h5a005a5a00, 5); // one wrong first key, one wrong second key
    repeat (50) @(posedge mclk);
    chk("osc", 11'h1, {10'h0, osc_run});
    send(64'h5a5aa55049, 5); // key, then traffic while asleep; a kept byte would spoil the next read
    chk("osc", 11'h0, {10'h0, osc_run});
    chk("wake oe", 11'h0, {10'h0, wk_oe});
    @(negedge mclk);
    host_wake_n = 1'b0;
    repeat (20) @(negedge mclk);
    host_wake_n = 1'b1;
    repeat (20) @(negedge mclk);
    chk("osc", 11'h1, {10'h0, osc_run});
    chk("wake pin", 11'h0, {10'h0, wk_lvl});
    chk("replies", 11'h0, 11'(h.got.size()));
    send(64'h4950, 2);
    rx(8'h96);
  endtask : t_sleep
  task automatic results;
    if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  // run takes about 10 ms of link time
  initial begin
    #30000000;
    n_errors++;
    results();
  end
  initial begin
    repeat (10) @(negedge mclk);
    rst_b = 1'b1;
    t_boot();
    t_regs();
    t_gpio();
    t_bus();
    t_sleep();
    results();
  end
endmodule : testbench
`default_nettype wire
